/* design/dvmr_pkg.sv */
// Purpose: Shared constants and types for the DQ reference mode register bank.
// Assumes: Both ends run on one 250 MHz command clock.
// Notes: Times are kept in their own units; cycle counts are derived here.
package dvmr_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned T_SHORT_NS = 100;
  localparam int unsigned T_MIDDLE_NS = 200;
  localparam int unsigned T_LONG_NS = 250;
  localparam int unsigned T_WEAK_MS = 1;
  // Settle deadlines round down; controller spacing rounds up.
  localparam int unsigned SETTLE_SHORT_CYC = (T_SHORT_NS * CLK_MHZ) / 1000;
  localparam int unsigned SETTLE_MIDDLE_CYC = (T_MIDDLE_NS * CLK_MHZ) / 1000;
  localparam int unsigned SETTLE_LONG_CYC = (T_LONG_NS * CLK_MHZ) / 1000;
  localparam int unsigned SPACE_SHORT_CYC = (T_SHORT_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned SPACE_MIDDLE_CYC = (T_MIDDLE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned WEAK_CYC = T_WEAK_MS * 1000 * CLK_MHZ;
  localparam int unsigned CNT_W = 18;

  // ----------------------------------------------------------------
  // Mode register addresses
  // ----------------------------------------------------------------
  localparam logic [5:0] MA_DEVICE_CAPABILITY_INFO = 6'h00;
  localparam logic [5:0] MA_BURST_PREAMBLE_RECOVERY_CFG = 6'h01;
  localparam logic [5:0] MA_READ_WRITE_LATENCY_CFG = 6'h02;
  localparam logic [5:0] MA_INVERSION_DRIVE_CFG = 6'h03;
  localparam logic [5:0] MA_REFRESH_THERMAL_STATUS = 6'h04;
  localparam logic [5:0] MA_GEOMETRY_INFO = 6'h08;
  localparam logic [5:0] MA_IMPEDANCE_CAL_RESET = 6'h0A;
  localparam logic [5:0] MA_TERMINATION_CFG = 6'h0B;
  localparam logic [5:0] MA_CA_REFERENCE_CFG = 6'h0C;
  localparam logic [5:0] MA_SET_POINT_TRAINING_CTRL = 6'h0D;
  localparam logic [5:0] MA_DQ_REFERENCE_CFG = 6'h0E;
  localparam logic [5:0] MA_LOWER_BYTE_CAL_INVERT = 6'h0F;
  localparam logic [5:0] MA_PARTIAL_REFRESH_BANK_MASK = 6'h10;
  localparam logic [5:0] MA_PARTIAL_REFRESH_SEGMENT_MASK = 6'h11;
  localparam logic [5:0] MA_OSCILLATOR_COUNT_LOW = 6'h12;
  localparam logic [5:0] MA_OSCILLATOR_COUNT_HIGH = 6'h13;
  localparam logic [5:0] MA_UPPER_BYTE_CAL_INVERT = 6'h14;
  localparam logic [5:0] MA_TERMINATION_ENABLES = 6'h16;
  localparam logic [5:0] MA_OSCILLATOR_RUN_TIME = 6'h17;
  localparam logic [5:0] MA_ROW_HAMMER_MITIGATION_CFG = 6'h18;
  localparam logic [5:0] MA_REPAIR_RESOURCE_INFO = 6'h19;
  localparam logic [5:0] MA_TEST_RESERVED_A = 6'h1E;
  localparam logic [5:0] MA_CAL_PATTERN_A = 6'h20;
  localparam logic [5:0] MA_TEST_RESERVED_B = 6'h27;
  localparam logic [5:0] MA_CAL_PATTERN_B = 6'h28;

  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam int unsigned DQ_CODE_MSB = 5;
  localparam int unsigned DQ_RANGE_BIT = 6;
  localparam int unsigned FAST_SETTLE_BIT = 3;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_CAL_PATTERN_A = 8'h5A;
  localparam logic [7:0] RST_CAL_PATTERN_B = 8'h3C;
  localparam logic [5:0] DQ_CODE_MAX = 6'h32;
  localparam logic [9:0] R0_MIN_PERMILLE = 10'h064;
  localparam logic [9:0] R1_MIN_PERMILLE = 10'h0DC;
  localparam logic [9:0] STEP_PERMILLE = 10'h004;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ACC_NONE = 2'b00,
    ACC_RO = 2'b01,
    ACC_WO = 2'b10,
    ACC_RW = 2'b11
  } dvmr_acc_t;

  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_READ = 2'b01,
    H_GAP = 2'b10
  } dvmr_hstate_t;

  function automatic dvmr_acc_t dvmr_acc_of(input logic [5:0] ma);
    case (ma)
      MA_DEVICE_CAPABILITY_INFO, MA_GEOMETRY_INFO, MA_OSCILLATOR_COUNT_LOW,
      MA_OSCILLATOR_COUNT_HIGH, MA_REPAIR_RESOURCE_INFO: dvmr_acc_of = ACC_RO;
      MA_IMPEDANCE_CAL_RESET: dvmr_acc_of = ACC_WO;
      MA_BURST_PREAMBLE_RECOVERY_CFG, MA_READ_WRITE_LATENCY_CFG, MA_INVERSION_DRIVE_CFG,
      MA_REFRESH_THERMAL_STATUS, MA_TERMINATION_CFG, MA_CA_REFERENCE_CFG,
      MA_SET_POINT_TRAINING_CTRL, MA_DQ_REFERENCE_CFG, MA_LOWER_BYTE_CAL_INVERT,
      MA_PARTIAL_REFRESH_BANK_MASK, MA_PARTIAL_REFRESH_SEGMENT_MASK,
      MA_UPPER_BYTE_CAL_INVERT, MA_TERMINATION_ENABLES, MA_OSCILLATOR_RUN_TIME,
      MA_ROW_HAMMER_MITIGATION_CFG, MA_CAL_PATTERN_A, MA_CAL_PATTERN_B: dvmr_acc_of = ACC_RW;
      default: dvmr_acc_of = ACC_NONE;
    endcase
  endfunction : dvmr_acc_of

  function automatic logic [7:0] dvmr_rst_of(input logic [5:0] ma);
    case (ma)
      MA_CAL_PATTERN_A: dvmr_rst_of = RST_CAL_PATTERN_A;
      MA_CAL_PATTERN_B: dvmr_rst_of = RST_CAL_PATTERN_B;
      default: dvmr_rst_of = RST_ZERO;
    endcase
  endfunction : dvmr_rst_of

endpackage : dvmr_pkg

/* design/dvmr_if.sv */
// Purpose: Mode register command link between controller and device.
// Assumes: Single command clock shared by both ends.
// Notes: Commands are one-cycle pulses; read data returns one cycle later.
interface dvmr_if;
  logic mrw;
  logic mrr;
  logic [5:0] ma;
  logic [7:0] op;
  logic [7:0] rd_op;
  logic rd_valid;

  modport ctrl (output mrw, output mrr, output ma, output op, input rd_op, input rd_valid);
  modport dev (input mrw, input mrr, input ma, input op, output rd_op, output rd_valid);
endinterface : dvmr_if

/* design/dvmr_device.sv */
// Purpose: Mode register bank with DQ reference code, range and settle timing.
// Assumes: Controller keeps command spacing; commands are one-cycle pulses.
// Notes: Reference level is reported in tenths of a percent of the I/O supply.
// Notes: Codes above the range top are stored as written; only the level clamps.
// Notes: A low clock enable freezes every register, including the settle count.

// Contract
// RQ1: Reference code taken from register 14 bits 5..0.
// RQ2: Register 14 bit 6 selects range.
// RQ3: Range 0 spans 10-30%, range 1 22-42%.
// RQ4: Each code unit moves reference 0.4%.
// RQ5: Controller spaces reference writes by step time.
// RQ6: Single step settles within 100 ns.
// RQ7: Multi-step change settles within 200 ns.
// RQ8: Full span change settles within 250 ns.
// RQ9: Fast settle off allows 1 ms settling.
// RQ10: Settle time counted from write capture edge.
// RQ11: Registers accessed only by read/write commands.
// RQ12: Access class limits reads and writes.
// RQ13: Register 32 resets to pattern 5AH.
// RQ14: Register 40 resets to pattern 3CH.
// RQ15: Writes to unused addresses change nothing.
module dvmr_device
  import dvmr_pkg::*;
#(
  parameter int unsigned WEAK_CYCLES = WEAK_CYC
) (
  // Clock, reset, enable
  input wire logic i_sys_clk,
  input wire logic i_srst,
  input wire logic i_ce,
  // Command link
  dvmr_if.dev link,
  // Reference state
  output logic [5:0] o_dq_vref_code,
  output logic o_dq_vref_range_sel,
  output logic [9:0] o_dq_vref_permille,
  output logic o_dq_vref_settling,
  output logic o_reference_fast_settle_enable
);

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [7:0] regs [64];
  logic [CNT_W-1:0] settle_cnt;
  logic [CNT_W-1:0] next_settle_cnt;
  logic [5:0] new_code;
  logic new_range;
  logic [5:0] step_diff;
  logic [5:0] clamp_code;
  logic [9:0] next_permille;
  logic [9:0] range_base;
  logic dq_wr;
  logic fast_wr;
  logic ce_wr;
  logic ce_rd;
  dvmr_acc_t rd_acc;
  logic range_change;
  logic full_change;
  logic multi_step;
  logic single_step;

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  // Commands count only on enabled edges; the link holds each for one cycle.
  assign ce_wr = i_ce && link.mrw;
  assign ce_rd = i_ce && link.mrr;

  // Writes that steer the reference logic directly.
  assign dq_wr = link.mrw && (link.ma == MA_DQ_REFERENCE_CFG);
  assign fast_wr = link.mrw && (link.ma == MA_SET_POINT_TRAINING_CTRL);

  // Class of the address being read; its read bit gates the answer.
  assign rd_acc = dvmr_acc_of(link.ma);

  // ----------------------------------------------------------------
  // Mode register array
  // ----------------------------------------------------------------
  // One flop byte per address; reset loads each byte's default value.

  // Only writable classes store; read-only, reserved and unused addresses ignore writes.
  for (genvar g = 0; g < 64; g++) begin : g_reg
    localparam logic [5:0] ADDR = 6'(g);
    localparam dvmr_acc_t ACC = dvmr_acc_of(ADDR);
    always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
        regs[g] <= dvmr_rst_of(ADDR); // RQ13 RQ14
      end else if (ce_wr && (link.ma == ADDR) && ACC[1]) begin
        regs[g] <= link.op; // RQ11 RQ12 RQ15
      end
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      link.rd_valid <= 1'b0;
      link.rd_op <= RST_ZERO;
    end else if (i_ce) begin
      link.rd_valid <= link.mrr; // RQ11
      if (ce_rd) begin
        // Write-only and unmapped addresses answer with zero.
        if (rd_acc[0]) begin
          link.rd_op <= regs[link.ma]; // RQ12
        end else begin
          link.rd_op <= RST_ZERO; // RQ12
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Reference code and level
  // ----------------------------------------------------------------
  always_comb begin
    new_code = link.op[DQ_CODE_MSB:0];
    new_range = link.op[DQ_RANGE_BIT];
    // Distance in codes between the stored and the requested setting.
    if (new_code > o_dq_vref_code) begin
      step_diff = 6'(new_code - o_dq_vref_code);
    end else begin
      step_diff = 6'(o_dq_vref_code - new_code);
    end
    // Codes past the top of the span hold the level at the range maximum.
    if (new_code > DQ_CODE_MAX) begin
      clamp_code = DQ_CODE_MAX;
    end else begin
      clamp_code = new_code;
    end
    if (new_range) begin
      range_base = R1_MIN_PERMILLE; // RQ3
    end else begin
      range_base = R0_MIN_PERMILLE; // RQ3
    end
    next_permille = range_base + 10'(clamp_code) * STEP_PERMILLE; // RQ3 RQ4
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_dq_vref_code <= RST_ZERO[5:0];
      o_dq_vref_range_sel <= 1'b0;
      o_dq_vref_permille <= R0_MIN_PERMILLE;
    end else if (i_ce && dq_wr) begin
      o_dq_vref_code <= new_code; // RQ1
      o_dq_vref_range_sel <= new_range; // RQ2
      o_dq_vref_permille <= next_permille; // RQ3 RQ4
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_reference_fast_settle_enable <= 1'b0;
    end else if (i_ce && fast_wr) begin
      o_reference_fast_settle_enable <= link.op[FAST_SETTLE_BIT]; // RQ9
    end
  end

  // ----------------------------------------------------------------
  // Settle window
  // ----------------------------------------------------------------
  // A range change crosses the span boundary, so it is timed as a full swing.
  assign range_change = (new_range != o_dq_vref_range_sel);
  assign full_change = range_change || (step_diff >= DQ_CODE_MAX);
  assign multi_step = !full_change && (step_diff > 6'h01);
  assign single_step = !full_change && (step_diff == 6'h01);

  // A new write restarts the window with its own length.
  // Rewriting the stored code and range with fast settling opens no window.
  always_comb begin
    next_settle_cnt = settle_cnt;
    if (settle_cnt != '0) begin
      next_settle_cnt = CNT_W'(settle_cnt - 1'b1);
    end
    if (dq_wr) begin
      if (!o_reference_fast_settle_enable) begin
        // Without fast settling every change takes the weak time.
        next_settle_cnt = CNT_W'(WEAK_CYCLES); // RQ9
      end else if (full_change) begin
        next_settle_cnt = CNT_W'(SETTLE_LONG_CYC); // RQ8
      end else if (multi_step) begin
        next_settle_cnt = CNT_W'(SETTLE_MIDDLE_CYC); // RQ7
      end else if (single_step) begin
        next_settle_cnt = CNT_W'(SETTLE_SHORT_CYC); // RQ6
      end
    end
  end

  // The window opens on the capture edge and closes at the deadline.
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      settle_cnt <= '0;
    end else if (i_ce) begin
      settle_cnt <= next_settle_cnt; // RQ10
    end
  end

  // The flag is taken from the next count so that it rises on the capture edge itself.
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_dq_vref_settling <= 1'b0;
    end else if (i_ce) begin
      o_dq_vref_settling <= (next_settle_cnt != '0); // RQ10
    end
  end

endmodule : dvmr_device

/* design/dvmr_host.sv */
// Purpose: Controller end issuing mode register reads and writes.
// Assumes: User raises one request at a time while o_ready is high.
// Notes: After a reference write all requests stall for the spacing time.
module dvmr_host
  import dvmr_pkg::*;
#(
  parameter int unsigned WEAK_CYCLES = WEAK_CYC
) (
  // Clock, reset, enable
  input wire logic i_sys_clk,
  input wire logic i_srst,
  input wire logic i_ce,
  // Command link
  dvmr_if.ctrl link,
  // User requests
  input wire logic i_wr_req,
  input wire logic i_rd_req,
  input wire logic [5:0] i_addr,
  input wire logic [7:0] i_wdata,
  // User answers
  output logic o_ready,
  output logic o_rvalid,
  output logic [7:0] o_rdata
);

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  dvmr_hstate_t state;
  dvmr_hstate_t next_state;
  logic [CNT_W-1:0] gap_cnt;
  logic [CNT_W-1:0] next_gap_cnt;
  logic [5:0] last_code;
  logic last_range;
  logic fast_settle;
  logic [5:0] step_diff;
  logic dq_wr;

  assign dq_wr = o_ready && i_wr_req && (i_addr == MA_DQ_REFERENCE_CFG);

  always_comb begin
    step_diff = (i_wdata[DQ_CODE_MSB:0] > last_code) ? 6'(i_wdata[DQ_CODE_MSB:0] - last_code)
                                                     : 6'(last_code - i_wdata[DQ_CODE_MSB:0]);
    next_state = state;
    next_gap_cnt = (gap_cnt != '0) ? CNT_W'(gap_cnt - 1'b1) : gap_cnt;
    case (state)
      H_IDLE: begin
        if (o_ready && i_rd_req) begin
          next_state = H_READ;
        end else if (dq_wr) begin
          next_state = H_GAP;
          if (!fast_settle) begin
            next_gap_cnt = CNT_W'(WEAK_CYCLES); // RQ9
          end else if ((step_diff > 6'h01) || (i_wdata[DQ_RANGE_BIT] != last_range)) begin
            next_gap_cnt = CNT_W'(SPACE_MIDDLE_CYC); // RQ5
          end else begin
            next_gap_cnt = CNT_W'(SPACE_SHORT_CYC); // RQ5
          end
        end
      end
      H_READ: begin
        if (link.rd_valid) begin
          next_state = H_IDLE;
        end
      end
      H_GAP: begin
        if (next_gap_cnt == '0) begin
          next_state = H_IDLE;
        end
      end
      default: begin
        next_state = H_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      state <= H_IDLE;
      gap_cnt <= '0;
      o_ready <= 1'b0;
    end else if (i_ce) begin
      state <= next_state;
      gap_cnt <= next_gap_cnt; // RQ10
      o_ready <= (next_state == H_IDLE) && !(o_ready && (i_rd_req || i_wr_req));
    end
  end

  // ----------------------------------------------------------------
  // Command drive
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      link.mrw <= 1'b0;
      link.mrr <= 1'b0;
      link.ma <= '0;
      link.op <= RST_ZERO;
    end else if (i_ce) begin
      link.mrr <= o_ready && i_rd_req; // RQ11
      link.mrw <= o_ready && i_wr_req && !i_rd_req; // RQ11
      if (o_ready && (i_rd_req || i_wr_req)) begin
        link.ma <= i_addr;
        link.op <= i_wdata;
      end
    end
  end

  // Shadow copies decide the spacing of the next reference write.
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      last_code <= RST_ZERO[5:0];
      last_range <= 1'b0;
      fast_settle <= 1'b0;
    end else if (i_ce && o_ready && i_wr_req && !i_rd_req) begin
      if (i_addr == MA_DQ_REFERENCE_CFG) begin
        last_code <= i_wdata[DQ_CODE_MSB:0];
        last_range <= i_wdata[DQ_RANGE_BIT]; // RQ5
      end
      if (i_addr == MA_SET_POINT_TRAINING_CTRL) begin
        fast_settle <= i_wdata[FAST_SETTLE_BIT]; // RQ9
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_rvalid <= 1'b0;
      o_rdata <= RST_ZERO;
    end else if (i_ce) begin
      o_rvalid <= (state == H_READ) && link.rd_valid;
      if ((state == H_READ) && link.rd_valid) begin
        o_rdata <= link.rd_op;
      end
    end
  end

endmodule : dvmr_host

/* tb/dvmr_checker.sv */
// Purpose: Concurrent checks on the mode register link and the reference outputs.
// Assumes: Clock enable is held high; one command clock domain.
// Notes: Exact settle lengths are measured by the bench; these bound them.
module dvmr_checker
  import dvmr_pkg::*;
(
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_srst,
  // Command link
  input wire logic mrw,
  input wire logic mrr,
  input wire logic [5:0] ma,
  input wire logic [7:0] op,
  input wire logic rd_valid,
  // Reference state
  input wire logic [5:0] o_dq_vref_code,
  input wire logic o_dq_vref_range_sel,
  input wire logic [9:0] o_dq_vref_permille,
  input wire logic o_dq_vref_settling,
  input wire logic o_reference_fast_settle_enable
);
  localparam int SHORT_N = SETTLE_SHORT_CYC;
  localparam int LONG_N = SETTLE_LONG_CYC;
  logic ref_wr;
  logic [5:0] op_code;
  logic op_range;
  logic op_fast;
  logic [9:0] clamp;
  assign ref_wr = mrw && (ma == MA_DQ_REFERENCE_CFG);
  assign op_code = op[5:0];
  assign op_range = op[DQ_RANGE_BIT];
  assign op_fast = op[FAST_SETTLE_BIT];
  assign clamp = (o_dq_vref_code > DQ_CODE_MAX) ? 10'(DQ_CODE_MAX) : 10'(o_dq_vref_code);
  localparam int SPACE_S = SPACE_SHORT_CYC;
  localparam int SPACE_M = SPACE_MIDDLE_CYC;
  logic [5:0] wr_step;
  logic full_wr;
  logic last_full;
  logic [7:0] since_wr;
  assign wr_step = (op_code > o_dq_vref_code) ? 6'(op_code - o_dq_vref_code)
                                              : 6'(o_dq_vref_code - op_code);
  assign full_wr = (op_range != o_dq_vref_range_sel) || (wr_step >= DQ_CODE_MAX);
  // Cycles since the last reference write, saturating, and whether it was a full swing.
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      since_wr <= 8'hFF;
      last_full <= 1'b0;
    end else if (ref_wr) begin
      since_wr <= 8'h01;
      last_full <= full_wr;
    end else if (since_wr != 8'hFF) begin
      since_wr <= since_wr + 8'h01;
    end
  end

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_srst);

  sequence s_short_wr;
    ref_wr && o_reference_fast_settle_enable && (op_range == o_dq_vref_range_sel) &&
      ((op_code == o_dq_vref_code + 6'h01) || (op_code + 6'h01 == o_dq_vref_code));
  endsequence
  sequence s_range_wr;
    ref_wr && o_reference_fast_settle_enable && (op_range != o_dq_vref_range_sel);
  endsequence

  a_read_gets_answer: assert property (mrr |=> rd_valid)
    else $error("read command got no answer");
  a_answer_has_cause: assert property (rd_valid |-> $past(mrr))
    else $error("read answer without a read command");
  a_code_from_write: assert property (ref_wr |=> o_dq_vref_code == $past(op_code))
    else $error("reference code not taken from write");
  a_range_from_write: assert property (ref_wr |=> o_dq_vref_range_sel == $past(op_range))
    else $error("reference range not taken from write");
  a_reference_holds: assert property (!ref_wr |=> $stable(o_dq_vref_code))
    else $error("reference code changed without its write");
  a_level_formula: assert property (o_dq_vref_permille ==
    (o_dq_vref_range_sel ? R1_MIN_PERMILLE : R0_MIN_PERMILLE) + STEP_PERMILLE * clamp)
    else $error("reference level does not match code and range");
  a_fast_bit_copy: assert property ((mrw && ma == MA_SET_POINT_TRAINING_CTRL) |=>
    o_reference_fast_settle_enable == $past(op_fast))
    else $error("fast settle bit not taken from write");
  a_short_step_settle: assert property (s_short_wr |=>
    o_dq_vref_settling [*8] ##[1:SHORT_N] !o_dq_vref_settling)
    else $error("single step settle window wrong");
  a_range_step_settle: assert property (s_range_wr |=>
    o_dq_vref_settling [*8] ##[1:LONG_N] !o_dq_vref_settling)
    else $error("range change settle window wrong");
  a_short_spacing: assert property (ref_wr |-> since_wr >= SPACE_S)
    else $error("reference writes closer than the short step time");
  a_full_spacing: assert property ((ref_wr && last_full) |-> since_wr >= SPACE_M)
    else $error("write after a full swing came before the middle step time");
endmodule : dvmr_checker

/* tb/dq_vref_mode_registers_bench.sv */
// Purpose: Drives the host user port and checks the device end through the link.
// Assumes: Both ends share one clock; clock enables are held high.
// Notes: The weak settle time is shortened to 200 cycles.
module dq_vref_mode_registers_bench
  import dvmr_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int unsigned WEAK = 200;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic wr_req = 1'b0;
  logic rd_req = 1'b0;
  logic [5:0] addr = 6'h00;
  logic [7:0] wdata = 8'h00;
  logic ready, rvalid, range, settling, fast;
  logic [7:0] rdata, got;
  logic [5:0] code;
  logic [9:0] permille;
  int mismatches = 0;
  int compares = 0;

  dvmr_if link_if ();
  dvmr_device #(.WEAK_CYCLES(WEAK)) dvmr_device_i (.i_sys_clk(clk), .i_srst(srst),
    .i_ce(1'b1), .link(link_if.dev), .o_dq_vref_code(code), .o_dq_vref_range_sel(range),
    .o_dq_vref_permille(permille), .o_dq_vref_settling(settling),
    .o_reference_fast_settle_enable(fast));
  dvmr_host #(.WEAK_CYCLES(WEAK)) dvmr_host_i (.i_sys_clk(clk), .i_srst(srst), .i_ce(1'b1),
    .link(link_if.ctrl), .i_wr_req(wr_req), .i_rd_req(rd_req), .i_addr(addr),
    .i_wdata(wdata), .o_ready(ready), .o_rvalid(rvalid), .o_rdata(rdata));
  dvmr_checker dvmr_checker_i (.i_sys_clk(clk), .i_srst(srst), .mrw(link_if.mrw),
    .mrr(link_if.mrr), .ma(link_if.ma), .op(link_if.op), .rd_valid(link_if.rd_valid),
    .o_dq_vref_code(code), .o_dq_vref_range_sel(range), .o_dq_vref_permille(permille),
    .o_dq_vref_settling(settling), .o_reference_fast_settle_enable(fast));

  initial begin
    forever #2 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Compare, bus and closing tasks
  // ----------------------------------------------------------------
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : print_verdict

  task automatic report(input logic [31:0] g, input logic [31:0] e);
    mismatches++;
    $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
  endtask : report

  task automatic check_byte(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) begin
      report(32'(g), 32'(e));
    end
  endtask : check_byte

  task automatic check_level(input logic [9:0] g, input logic [9:0] e);
    compares++;
    if (g !== e) begin
      report(32'(g), 32'(e));
    end
  endtask : check_level

  task automatic check_count(input int g, input int e);
    compares++;
    if (g != e) begin
      report(g, e);
    end
  endtask : check_count

  task automatic tick(inout int n, input int lim);
    @(posedge clk);
    #1;
    n++;
    if (n > lim) begin
      report(32'(n), 32'(lim));
      print_verdict();
    end
  endtask : tick

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    int n;
    n = 0;
    while (ready !== 1'b1) tick(n, 1000);
    addr = a;
    wdata = d;
    wr_req = 1'b1;
    tick(n, 2000);
    wr_req = 1'b0;
    tick(n, 2000);
  endtask : wr

  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    int n;
    n = 0;
    while (ready !== 1'b1) tick(n, 1000);
    addr = a;
    rd_req = 1'b1;
    tick(n, 2000);
    rd_req = 1'b0;
    n = 0;
    while (rvalid !== 1'b1) tick(n, 20);
    d = rdata;
  endtask : rd

  task automatic ref_step(input logic [7:0] d, input int cyc, input logic [9:0] lvl);
    int n, c;
    n = 0;
    c = 0;
    wr(MA_DQ_REFERENCE_CFG, d);
    while (settling !== 1'b1) tick(n, 8);
    while (settling === 1'b1) tick(c, 1000);
    check_count(c, cyc);
    check_level(permille, lvl);
    check_byte({1'b0, range, code}, d & 8'h7F);
  endtask : ref_step

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    #1;
    srst = 1'b0;
    rd(MA_CAL_PATTERN_A, got);
    check_byte(got, 8'h5A);
    rd(MA_CAL_PATTERN_B, got);
    check_byte(got, 8'h3C);
    check_level(permille, 10'h064);
    $display("test reset values done");
    wr(MA_SET_POINT_TRAINING_CTRL, 8'h08);
    check_byte({7'h00, fast}, 8'h01);
    ref_step(8'h01, SETTLE_SHORT_CYC, 10'h068);
    ref_step(8'h00, SETTLE_SHORT_CYC, 10'h064);
    ref_step(8'h32, SETTLE_LONG_CYC, 10'h12C);
    ref_step(8'h05, SETTLE_MIDDLE_CYC, 10'h078);
    ref_step(8'h45, SETTLE_LONG_CYC, 10'h0F0);
    ref_step(8'h72, SETTLE_MIDDLE_CYC, 10'h1A4);
    rd(MA_DQ_REFERENCE_CFG, got);
    check_byte(got, 8'h72);
    $display("test reference steps done");
    wr(6'h3F, 8'hFF);
    rd(6'h3F, got);
    check_byte(got, 8'h00);
    wr(MA_DEVICE_CAPABILITY_INFO, 8'hFF);
    rd(MA_DEVICE_CAPABILITY_INFO, got);
    check_byte(got, 8'h00);
    wr(MA_IMPEDANCE_CAL_RESET, 8'hFF);
    rd(MA_IMPEDANCE_CAL_RESET, got);
    check_byte(got, 8'h00);
    wr(MA_TEST_RESERVED_A, 8'hFF);
    wr(MA_TEST_RESERVED_B, 8'h55);
    rd(MA_TEST_RESERVED_B, got);
    check_byte(got, 8'h00);
    rd(MA_CAL_PATTERN_A, got);
    check_byte(got, 8'h5A);
    check_byte({1'b0, range, code}, 8'h72);
    wr(MA_CAL_PATTERN_B, 8'hA5);
    rd(MA_CAL_PATTERN_B, got);
    check_byte(got, 8'hA5);
    $display("test access classes done");
    wr(MA_SET_POINT_TRAINING_CTRL, 8'h00);
    check_byte({7'h00, fast}, 8'h00);
    ref_step(8'h73, WEAK, 10'h1A4);
    $display("test weak settle done");
    print_verdict();
  end
endmodule : dq_vref_mode_registers_bench
